//--- rtl/umdci_pkg.sv
package umdci_pkg;

    // ============================================================
    // command word layout (word bit n sits at vector index n-1)
    // ============================================================
    localparam int unsigned WORD_W     = 14;
    localparam int unsigned PAY_W      = 6;
    localparam int unsigned CHK_W      = 7;
    localparam int unsigned PAY_MSB    = 13;
    localparam int unsigned PAY_LSB    = 8;
    localparam int unsigned SEQ_POS    = 7;
    localparam int unsigned CHK_MSB    = 6;
    localparam int unsigned TRUE_LSB   = 7;

    // ============================================================
    // parameter assembly
    // ============================================================
    localparam int unsigned PARAM_W    = 26;
    localparam int unsigned PIECES     = 5;
    localparam int unsigned ACC_W      = 24;
    localparam int unsigned TAIL_W     = 2;
    localparam int unsigned OPER_W     = 18;
    localparam int unsigned SHORT_MAX  = 3;

    // ============================================================
    // retry handling
    // ============================================================
    localparam logic [2:0]  ERR_LIMIT  = 3'h7;
    localparam logic        SEQ_FIRST  = 1'h1;

    // ============================================================
    // mode codes (payload bits 14..9)
    // ============================================================
    localparam logic [5:0]  MODE_TIME_BASE = 6'h08;
    localparam logic [5:0]  MODE_NAV       = 6'h09;
    localparam logic [5:0]  MODE_SWITCH    = 6'h0A;
    localparam logic [5:0]  MODE_SECTOR    = 6'h0B;
    localparam logic [5:0]  MODE_SINGLE    = 6'h0C;
    localparam logic [5:0]  MODE_TERMINATE = 6'h10;
    localparam logic [5:0]  MODE_ALT_TB4   = 6'h13;
    localparam logic [5:0]  MODE_ALT_TB7   = 6'h14;
    localparam logic [5:0]  MODE_TARGET    = 6'h19;

    // ============================================================
    // data words needed per mode
    // ============================================================
    localparam logic [5:0]  CNT_TIME_BASE  = 6'h01;
    localparam logic [5:0]  CNT_NAV        = 6'h23;
    localparam logic [5:0]  CNT_SWITCH     = 6'h02;
    localparam logic [5:0]  CNT_SECTOR     = 6'h02;
    localparam logic [5:0]  CNT_SINGLE     = 6'h03;
    localparam logic [5:0]  CNT_ALT_TB     = 6'h01;
    localparam logic [5:0]  CNT_TARGET     = 6'h2D;
    localparam logic [5:0]  CNT_NONE       = 6'h00;

endpackage

//--- rtl/umdci_word_check.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// word splitter and true/complement test
// ============================================================
module umdci_word_check
    import umdci_pkg::*;
(
    input  wire logic [WORD_W-1:0] word,
    output logic      [PAY_W-1:0]  payload,
    output logic                   seq_bit,
    output logic                   check_ok
);

    // sequence bit is kept apart so it never reaches the payload
    assign payload  = word[PAY_MSB:PAY_LSB];
    assign seq_bit  = word[SEQ_POS];
    // upper seven bits must be the exact inverse of the lower seven
    assign check_ok = (word[WORD_W-1:TRUE_LSB] == ~word[CHK_MSB:0]);

endmodule

`default_nettype wire

//--- rtl/umdci_interp.sv
`timescale 1ns/10ps
`default_nettype none

module umdci_interp
    import umdci_pkg::*;
(
    input  wire logic                CLK_SYS,
    input  wire logic                RESET,
    input  wire logic                WORD_VALID,
    input  wire logic [WORD_W-1:0]   WORD_DATA,
    input  wire logic                WORD_TYPE_FLAG,
    output logic                     WORD_ACK,
    output logic                     WORD_ERROR,
    output logic                     SEQ_ERROR,
    output logic                     ABANDON,
    output logic                     MODE_ENTERED,
    output logic                     TERMINATED,
    output logic                     MODE_ACTIVE,
    output logic      [PAY_W-1:0]    ACTIVE_MODE,
    output logic                     PARAM_VALID,
    output logic      [3:0]          PARAM_INDEX,
    output logic      [PARAM_W-1:0]  PARAM_VALUE,
    output logic                     ROUTINE_DONE,
    output logic      [PAY_W-1:0]    ROUTINE_CODE,
    output logic      [OPER_W-1:0]   ROUTINE_OPERAND,
    output logic                     TIME_BASE_UPDATE,
    output logic      [2:0]          ERROR_COUNT
);

    // ============================================================
    // helpers
    // ============================================================

    // data words a mode must collect; zero marks terminate or an unassigned code
    function automatic logic [5:0] words_needed(input logic [PAY_W-1:0] code);
        logic [5:0] n;
        n = CNT_NONE;
        unique case (code)
            MODE_TIME_BASE : n = CNT_TIME_BASE;
            MODE_NAV       : n = CNT_NAV;
            MODE_SWITCH    : n = CNT_SWITCH;
            MODE_SECTOR    : n = CNT_SECTOR;
            MODE_SINGLE    : n = CNT_SINGLE;
            MODE_ALT_TB4   : n = CNT_ALT_TB;
            MODE_ALT_TB7   : n = CNT_ALT_TB;
            MODE_TARGET    : n = CNT_TARGET;
            default        : n = CNT_NONE;
        endcase
        return n;
    endfunction

    // modes whose data builds 26-bit parameters from five pieces
    function automatic logic builds_params(input logic [PAY_W-1:0] code);
        return (code == MODE_NAV) || (code == MODE_TARGET);
    endfunction

    // three-word operand history, newest payload at the bottom; the
    // sequence bit has no way in, since only the payload is passed
    function automatic logic [OPER_W-1:0] shift_oper(input logic [OPER_W-1:0] hist,
                                                     input logic [PAY_W-1:0]  pay);
        return {hist[OPER_W-PAY_W-1:0], pay};
    endfunction

    // two states suffice: the counters carry the rest of the progress
    typedef enum logic {UMDCI_IDLE, UMDCI_COLLECT} umdci_state_t;

    // ============================================================
    // state
    // ============================================================
    umdci_state_t      state_q;
    logic [PAY_W-1:0]  mode_q;
    logic [5:0]        left_q;
    logic [2:0]        piece_q;
    logic [3:0]        pidx_q;
    logic [ACC_W-1:0]  acc_q;
    logic [OPER_W-1:0] oper_q;
    logic              expect_seq_q;
    logic [2:0]        err_q;

    // word fields, split off combinationally
    logic [PAY_W-1:0]  payload;
    logic              seq_bit;
    logic              check_ok;

    // one splitter feeds every consumer, so field positions live in one place
    umdci_word_check u_check (
        .word     (WORD_DATA),
        .payload  (payload),
        .seq_bit  (seq_bit),
        .check_ok (check_ok)
    );

    // ============================================================
    // word classification
    // ============================================================
    logic       collecting;
    logic       is_term;
    logic [5:0] need;
    logic       mode_ok;
    logic       data_ok;
    logic       seq_bad;
    logic       good;
    logic       bad;
    logic       take_mode;
    logic       take_term;
    logic       take_data;
    logic       last_word;
    logic       last_piece;
    logic [2:0] err_next;
    logic       give_up;
    logic       param_done;
    logic       routine_end;

    always_comb begin
        collecting = (state_q == UMDCI_COLLECT);
        is_term    = (payload == MODE_TERMINATE);
        need       = words_needed(payload);
        // mode words carry a zero sequence bit; while collecting only
        // terminate gets through, other modes are refused as errors
        mode_ok    = WORD_TYPE_FLAG && !seq_bit
                     && (is_term || (!collecting && need != CNT_NONE));
        // continuity: each data word must flip the sequence bit
        seq_bad    = collecting && !WORD_TYPE_FLAG
                     && (seq_bit != expect_seq_q);
        data_ok    = collecting && !WORD_TYPE_FLAG && !seq_bad;
        good       = WORD_VALID && check_ok && (mode_ok || data_ok);
        bad        = WORD_VALID && !good;
        take_term  = good && WORD_TYPE_FLAG && is_term;
        take_mode  = good && WORD_TYPE_FLAG && !is_term;
        take_data  = good && !WORD_TYPE_FLAG;
        last_word  = (left_q == 6'h01);
        last_piece = (piece_q == 3'(PIECES - 1));
        err_next   = err_q + 3'h1;
        give_up    = bad && (err_next == ERR_LIMIT);
        // closing events, shared by the status and result registers
        param_done = take_data && last_piece && builds_params(mode_q);
        routine_end = take_data && last_word;
    end

    // ============================================================
    // routine sequencing
    // ============================================================

    // abandon and terminate both fall back to waiting for a mode word
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            state_q <= UMDCI_IDLE;
            mode_q  <= '0;
            left_q  <= '0;
        end else if (give_up || take_term) begin
            state_q <= UMDCI_IDLE;
            left_q  <= '0;
        end else if (take_mode) begin
            state_q <= UMDCI_COLLECT;
            mode_q  <= payload;
            left_q  <= need;
        end else if (take_data) begin
            left_q  <= left_q - 6'h01;
            if (last_word) begin
                state_q <= UMDCI_IDLE;
            end
        end
    end

    // sequence expectation: first data word after a mode carries one
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            expect_seq_q <= SEQ_FIRST;
        end else if (take_mode) begin
            expect_seq_q <= SEQ_FIRST;
        end else if (take_data) begin
            expect_seq_q <= ~expect_seq_q;
        end
    end

    // consecutive rejected words, whatever they carry; any accepted word clears it
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            err_q <= '0;
        end else if (give_up || good) begin
            err_q <= '0;
        end else if (bad) begin
            err_q <= err_next;
        end
    end

    // ============================================================
    // data assembly
    // ============================================================

    // pieces land most significant first; fifth piece gives two bits
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            piece_q <= '0;
            pidx_q  <= '0;
            acc_q   <= '0;
            oper_q  <= '0;
        end else if (take_mode) begin
            piece_q <= '0;
            pidx_q  <= '0;
            acc_q   <= '0;
            oper_q  <= '0;
        end else if (take_data) begin
            // payload only: the sequence bit is dropped here
            oper_q <= shift_oper(oper_q, payload);
            if (last_piece) begin
                piece_q <= '0;
                pidx_q  <= pidx_q + 4'h1;
                acc_q   <= '0;
            end else begin
                piece_q <= piece_q + 3'h1;
                acc_q   <= {acc_q[ACC_W-PAY_W-1:0], payload};
            end
        end
    end

    // ============================================================
    // outputs
    // ============================================================

    // event pulses, one cycle after the word that caused them
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            WORD_ACK     <= 1'b0;
            WORD_ERROR   <= 1'b0;
            SEQ_ERROR    <= 1'b0;
            ABANDON      <= 1'b0;
            MODE_ENTERED <= 1'b0;
            TERMINATED   <= 1'b0;
        end else begin
            WORD_ACK     <= good;
            WORD_ERROR   <= bad;
            SEQ_ERROR    <= WORD_VALID && check_ok && seq_bad;
            ABANDON      <= give_up;
            MODE_ENTERED <= take_mode;
            TERMINATED   <= take_term;
        end
    end

    // a finished parameter leaves only once all five pieces passed checks
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            PARAM_VALID <= 1'b0;
            PARAM_INDEX <= '0;
            PARAM_VALUE <= '0;
        end else begin
            PARAM_VALID <= param_done;
            if (param_done) begin
                PARAM_INDEX <= pidx_q;
                PARAM_VALUE <= {acc_q, payload[PAY_W-1:PAY_W-TAIL_W]};
            end
        end
    end

    // completion of a routine with its short operand (one to three words)
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ROUTINE_DONE     <= 1'b0;
            TIME_BASE_UPDATE <= 1'b0;
            ROUTINE_CODE     <= '0;
            ROUTINE_OPERAND  <= '0;
        end else begin
            ROUTINE_DONE     <= routine_end;
            TIME_BASE_UPDATE <= routine_end
                                && (mode_q == MODE_TIME_BASE);
            if (routine_end) begin
                ROUTINE_CODE    <= mode_q;
                // parameter modes leave the last three pieces here too;
                // only short modes give it meaning
                ROUTINE_OPERAND <= shift_oper(oper_q, payload);
            end
        end
    end

    // ============================================================
    // live status
    // ============================================================

    // straight from state registers; a registered copy would lag a cycle
    assign MODE_ACTIVE = collecting;
    assign ACTIVE_MODE = mode_q;
    assign ERROR_COUNT = err_q;

endmodule

`default_nettype wire

//--- dv/umdci_sender.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// decoder stand-in: hands over one checked word per call
// ============================================================
module umdci_sender
    import umdci_pkg::*;
(
    input  wire logic              clk,
    output logic                   valid,
    output logic      [WORD_W-1:0] data,
    output logic                   typ
);
    // idle lines at time zero
    initial begin
        valid = 1'b0;
        data  = 14'h0000;
        typ   = 1'b0;
    end

    // bad flips one check bit; released lines show the inverse of the last word
    task automatic send(input logic t, input logic [5:0] p, input logic s, input logic bad);
        @(posedge clk);
        #1;
        valid = 1'b1;
        typ   = t;
        data  = {p, s, ~{p, s}} ^ {13'h0000, bad};
        @(posedge clk);
        #1;
        valid = 1'b0;
        data  = ~data;
        typ   = ~typ;
    endtask
endmodule

`default_nettype wire

//--- dv/umdci_interp_sva.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// port checker for the command interpreter
// ============================================================
module umdci_interp_sva
    import umdci_pkg::*;
(
    input wire logic              CLK_SYS,
    input wire logic              RESET,
    input wire logic              WORD_VALID,
    input wire logic [WORD_W-1:0] WORD_DATA,
    input wire logic              WORD_TYPE_FLAG,
    input wire logic              WORD_ACK,
    input wire logic              WORD_ERROR,
    input wire logic              SEQ_ERROR,
    input wire logic              ABANDON,
    input wire logic              MODE_ENTERED,
    input wire logic              TERMINATED,
    input wire logic              MODE_ACTIVE,
    input wire logic [PAY_W-1:0]  ACTIVE_MODE,
    input wire logic              ROUTINE_DONE,
    input wire logic [PAY_W-1:0]  ROUTINE_CODE,
    input wire logic              TIME_BASE_UPDATE,
    input wire logic [2:0]        ERROR_COUNT
);
    logic [5:0] pay_q;
    logic       code_known;

    // assigned codes, terminate included; a plain signal so properties can negate it
    assign code_known = WORD_DATA[13:8] inside {MODE_TIME_BASE, MODE_NAV, MODE_SWITCH,
        MODE_SECTOR, MODE_SINGLE, MODE_TERMINATE, MODE_ALT_TB4, MODE_ALT_TB7, MODE_TARGET};

    // payload one cycle back, so entry can be tied to the word that caused it
    always_ff @(posedge CLK_SYS) begin
        pay_q <= WORD_DATA[13:8];
    end

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    // ============================================================
    // word classes
    // ============================================================
    sequence s_mode;
        WORD_VALID && WORD_TYPE_FLAG && !WORD_DATA[7] && (WORD_DATA[13:7] == ~WORD_DATA[6:0]);
    endsequence
    sequence s_known;
        code_known;
    endsequence

    chk_one_answer: assert property (WORD_VALID |=> WORD_ACK != WORD_ERROR)
        else $error("word got no single answer");
    chk_no_stray: assert property (
        !WORD_VALID |=> !WORD_ACK && !WORD_ERROR && !TERMINATED)
        else $error("answer without a word");
    chk_bad_check: assert property (
        WORD_VALID && (WORD_DATA[13:7] != ~WORD_DATA[6:0]) |=> WORD_ERROR && !WORD_ACK)
        else $error("complement mismatch accepted");
    chk_mode_seq: assert property (
        WORD_VALID && WORD_TYPE_FLAG && WORD_DATA[7] |=> WORD_ERROR)
        else $error("mode word with sequence bit set accepted");
    chk_unknown_code: assert property (
        s_mode ##0 !code_known |=> WORD_ERROR && !MODE_ENTERED)
        else $error("unassigned code accepted");
    chk_mode_entry: assert property (s_mode ##0 s_known ##0 (!MODE_ACTIVE &&
        WORD_DATA[13:8] != MODE_TERMINATE) |=> MODE_ENTERED && MODE_ACTIVE && ACTIVE_MODE == pay_q)
        else $error("mode entry wrong");
    chk_stop_now: assert property (s_mode ##0 (WORD_DATA[13:8] == MODE_TERMINATE)
        |=> TERMINATED && !MODE_ACTIVE && ERROR_COUNT == 3'h0)
        else $error("terminate not honoured");
    chk_idle_data: assert property (
        WORD_VALID && !WORD_TYPE_FLAG && !MODE_ACTIVE |=> WORD_ERROR)
        else $error("data word taken while idle");
    chk_seq_flag: assert property (SEQ_ERROR |-> WORD_ERROR)
        else $error("sequence fault without reject");
    chk_abandon_step: assert property (ABANDON |-> WORD_ERROR && !MODE_ACTIVE
        && ERROR_COUNT == 3'h0 && $past(ERROR_COUNT) == 3'h6)
        else $error("abandon at wrong count");
    chk_count_step: assert property (WORD_ERROR && !ABANDON |->
        ERROR_COUNT == $past(ERROR_COUNT) + 3'h1)
        else $error("error count did not step");
    chk_tb_pulse: assert property (TIME_BASE_UPDATE |-> ROUTINE_DONE
        && ROUTINE_CODE == MODE_TIME_BASE && !MODE_ACTIVE)
        else $error("time base update out of place");
endmodule

bind umdci_interp umdci_interp_sva u_sva (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .WORD_VALID(WORD_VALID), .WORD_DATA(WORD_DATA),
    .WORD_TYPE_FLAG(WORD_TYPE_FLAG), .WORD_ACK(WORD_ACK), .WORD_ERROR(WORD_ERROR),
    .SEQ_ERROR(SEQ_ERROR), .ABANDON(ABANDON), .MODE_ENTERED(MODE_ENTERED),
    .TERMINATED(TERMINATED), .MODE_ACTIVE(MODE_ACTIVE), .ACTIVE_MODE(ACTIVE_MODE),
    .ROUTINE_DONE(ROUTINE_DONE), .ROUTINE_CODE(ROUTINE_CODE),
    .TIME_BASE_UPDATE(TIME_BASE_UPDATE), .ERROR_COUNT(ERROR_COUNT)
);

`default_nettype wire

//--- dv/umdci_interp_tb.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// self-checking bench for the command interpreter
// ============================================================
module umdci_interp_tb
    import umdci_pkg::*;
();

    localparam logic [5:0] CODES [8] = '{MODE_TIME_BASE, MODE_NAV, MODE_SWITCH, MODE_SECTOR,
        MODE_SINGLE, MODE_ALT_TB4, MODE_ALT_TB7, MODE_TARGET};
    localparam int CNTS [8] = '{1, 35, 2, 2, 3, 1, 1, 45};

    logic        clk_sys, reset, w_valid, w_type, ack, err, seq_err, abandon;
    logic        entered, terminated, active, p_valid, done, tb_upd;
    logic [13:0] w_data;
    logic [5:0]  act_mode, r_code;
    logic [3:0]  p_index;
    logic [25:0] p_value;
    logic [17:0] r_oper;
    logic [2:0]  e_count;
    int          errors, n_compared;

    umdci_sender u_send (.clk(clk_sys), .valid(w_valid), .data(w_data), .typ(w_type));

    umdci_interp u_dut (
        .CLK_SYS(clk_sys), .RESET(reset), .WORD_VALID(w_valid), .WORD_DATA(w_data),
        .WORD_TYPE_FLAG(w_type), .WORD_ACK(ack), .WORD_ERROR(err), .SEQ_ERROR(seq_err),
        .ABANDON(abandon), .MODE_ENTERED(entered), .TERMINATED(terminated),
        .MODE_ACTIVE(active), .ACTIVE_MODE(act_mode), .PARAM_VALID(p_valid),
        .PARAM_INDEX(p_index), .PARAM_VALUE(p_value), .ROUTINE_DONE(done),
        .ROUTINE_CODE(r_code), .ROUTINE_OPERAND(r_oper), .TIME_BASE_UPDATE(tb_upd),
        .ERROR_COUNT(e_count)
    );

    // 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [25:0] got, input logic [25:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // payload pattern that differs from word to word
    function automatic logic [5:0] pay(input int i);
        return 6'(i * 11 + 5);
    endfunction

    // every data-taking mode run to its end, parameters rebuilt here
    task automatic t_modes();
        logic [25:0] acc;
        logic [17:0] opnd;
        logic [5:0]  p;
        logic        pv, last;
        logic [3:0]  want;
        acc = 26'h0;
        for (int m = 0; m < 8; m++) begin
            u_send.send(1'b1, CODES[m], 1'b0, 1'b0);
            chk(26'({ack, entered, active, act_mode}), 26'({3'h7, CODES[m]}), "entry");
            opnd = 18'h0;
            for (int i = 0; i < CNTS[m]; i++) begin
                p = pay(i);
                u_send.send(1'b0, p, i % 2 == 0, 1'b0);
                opnd = {opnd[11:0], p};
                acc = (i % 5 == 4) ? {acc[23:0], p[5:4]} : {acc[19:0], p};
                pv = (CNTS[m] > 5) && (i % 5 == 4);
                last = (i == CNTS[m] - 1);
                want = {1'b1, pv, last, !last};
                chk(26'({ack, p_valid, done, active}), 26'(want), "step");
                if (pv) begin
                    chk(26'(p_index), 26'(i / 5), "slot");
                    chk(p_value, acc, "param");
                end
            end
            chk(26'({r_code, tb_upd}), 26'({CODES[m], m == 0}), "end");
            if (CNTS[m] <= 3) chk(26'(r_oper), 26'(opnd), "operand");
        end
        $display("test modes done");
    endtask

    // rejects while idle, a broken alternation, then six more for seven in a row
    task automatic t_errors();
        logic [8:0] bad [4];
        bad = '{{1'b1, MODE_SINGLE, 2'b01}, {1'b1, MODE_NAV, 2'b10}, {1'b1, 6'h01, 2'b00},
            {1'b0, 6'h15, 2'b10}};
        for (int k = 0; k < 4; k++) begin
            u_send.send(bad[k][8], bad[k][7:2], bad[k][1], bad[k][0]);
            chk(26'({err, ack, entered}), 26'h4, "reject");
            chk(26'(e_count), 26'(k + 1), "reject count");
        end
        u_send.send(1'b1, MODE_SINGLE, 1'b0, 1'b0);
        chk(26'(e_count), 26'h0, "count cleared");
        u_send.send(1'b0, 6'h2A, 1'b1, 1'b0);
        u_send.send(1'b0, 6'h2B, 1'b1, 1'b0);
        chk(26'({seq_err, err, e_count}), 26'h19, "repeat seq");
        for (int k = 2; k <= 7; k++) begin
            u_send.send(1'b0, 6'h2B, 1'b0, 1'b1);
            chk(26'({abandon, active}), 26'({k == 7, k != 7}), "retry");
            chk(26'(e_count), 26'(k % 7), "retry count");
        end
        $display("test errors done");
    endtask

    // terminate idle and mid-collection; a MODE_TARGET word refused meanwhile
    task automatic t_term();
        u_send.send(1'b1, MODE_TERMINATE, 1'b0, 1'b0);
        chk(26'({terminated, ack, entered}), 26'h6, "idle stop");
        u_send.send(1'b1, MODE_NAV, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++) u_send.send(1'b0, pay(i), i % 2 == 0, 1'b0);
        u_send.send(1'b1, MODE_TARGET, 1'b0, 1'b0);
        chk(26'({err, active, act_mode}), 26'({2'h3, MODE_NAV}), "busy");
        u_send.send(1'b1, MODE_TERMINATE, 1'b0, 1'b0);
        chk(26'({terminated, active, p_valid, e_count}), 26'h20, "abort");
        u_send.send(1'b0, 6'h01, 1'b1, 1'b0);
        chk(26'(err), 26'h1, "data after stop");
        $display("test terminate done");
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        errors = 0;
        n_compared = 0;
        reset = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        t_modes();
        t_errors();
        t_term();
        wrap_up();
    end

    // hang guard: the whole run needs well under this many cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        $display("wrong value at %0t: run hung", $time);
        wrap_up();
    end
endmodule

`default_nettype wire
